// [rtl/fswg_status_gate.sv]
// fswg_status_gate: status register and instruction gate of a
// serial flash. decodes whole frames, keeps busy, permit and the
// non-volatile status bits, and hands array work to a sequencer.
// assumes: sequencer outside pulses op_done once per op_start.
//
// Summary of operation
// RULE1: register read repeats the status byte until chip select rises.
// RULE2: bit 0 is read-only busy, 1 while an internal cycle runs.
// RULE3: bit 1 shows the modify-permit latch.
// RULE4: only set-permit sets the latch; the status write data byte never moves it.
// RULE5: bits 2 to 5 hold the non-volatile block protection level.
// RULE6: bit 6 is the non-volatile four-lane enable.
// RULE7: bit 7 is the non-volatile status lock, qualified by protect pin.
// RULE8: protection, four-lane and lock bits change only by status write.
// RULE9: all eight status bits read zero after reset.
// RULE10: busy stays set for the whole internal operation.
// RULE11: while busy only reads, resets and suspend are accepted.
// RULE12: busy clears on completion, pass or fail; new instructions follow.
// RULE13: permit-requiring operations are refused while the latch is 0.
// RULE14: a complete set-permit instruction sets the latch.
// RULE15: host issues set-permit before each modifying instruction.
// RULE16: clear-permit or completion of any write clears the latch.
// RULE17: volatile register writes need no permit.
// RULE18: lock set and protect pin low makes status write ignored.
// RULE19: new non-volatile bits apply at write end, busy held meanwhile.
`timescale 1ns/1ns
`default_nettype none
`include "fswg_cfg.svh"
module fswg_status_gate #(
  parameter int SR_WRITE_NS = `FSWG_SR_WRITE_NS
) (
  input  wire logic  sys_clk,
  input  wire logic  rst,
  input  wire logic  cs_n,
  input  wire logic  sck,
  input  wire logic  si,
  input  wire logic  wp_n,
  input  wire logic  op_done,
  output logic       so_out,
  output logic       so_oe,
  output logic       op_busy_flag,
  output logic       modify_permit_latch,
  output logic [3:0] prot_level,
  output logic       four_lane_enable,
  output logic       status_lock,
  output logic       op_start,
  output logic [7:0] op_code,
  output logic       suspend_req,
  output logic       soft_reset_req
);
  localparam int SR_CYC = (SR_WRITE_NS * `FSWG_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] PERMIT_OPS [`FSWG_PERMIT_OP_NUM] =
    `FSWG_PERMIT_OPS;

  if (SR_CYC < 1 || SR_CYC >= (1 << `FSWG_TIMER_W)) begin : g_chk
    $error("status write time does not fit the timer");
  end

  fswg_ser_if ser ();

  fswg_shift u_shift (
    .sys_clk (sys_clk),
    .rst     (rst),
    .cs_n    (cs_n),
    .sck     (sck),
    .si      (si),
    .so_out  (so_out),
    .so_oe   (so_oe),
    .ser     (ser.shifter)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  fswg_pkg::fswg_state_e state_q, state_d;
  logic [`FSWG_TIMER_W-1:0] timer_q, timer_d;
  logic [`FSWG_SR_NV_W-1:0] nv_q, nv_d, pend_q, pend_d;
  logic       permit_q, permit_d, busy_q, busy_d;
  logic [7:0] opc_q, opc_d, data1_q, data1_d, tx_byte_q, tx_byte_d;
  logic [7:0] op_code_q, op_code_d, status;
  logic       opc_vld_q, opc_vld_d, arm_q, arm_d, tx_en_q, tx_en_d;
  logic [1:0] nb_q, nb_d;
  logic       start_q, start_d, susp_q, susp_d, srst_q, srst_d;
  logic       idle, need_permit, whole, sr_locked, chip_erase;

  // ****************************************************************
  // frame decode and status update
  // ****************************************************************
  always_comb begin
    status = {nv_q, permit_q, busy_q};                   // RULE2 RULE3
    idle   = (state_q == fswg_pkg::FSWG_ST_IDLE);
    need_permit = 1'b0;
    for (int i = 0; i < `FSWG_PERMIT_OP_NUM; i++) begin
      if (opc_q == PERMIT_OPS[i]) begin
        need_permit = 1'b1;
      end
    end
    whole      = opc_vld_q && ser.frame_aligned;
    sr_locked  = nv_q[`FSWG_NV_LOCK_BIT] && !wp_n;
    chip_erase = (opc_q == `FSWG_OP_CHIP_ERASE_A) ||
                 (opc_q == `FSWG_OP_CHIP_ERASE_B);
    state_d   = state_q;
    timer_d   = timer_q;
    nv_d      = nv_q;
    pend_d    = pend_q;
    permit_d  = permit_q;
    opc_d     = opc_q;
    opc_vld_d = opc_vld_q;
    data1_d   = data1_q;
    nb_d      = nb_q;
    arm_d     = arm_q;
    tx_en_d   = tx_en_q;
    tx_byte_d = tx_byte_q;
    op_code_d = op_code_q;
    start_d   = 1'b0;
    susp_d    = 1'b0;
    srst_d    = 1'b0;
    if (ser.byte_stb) begin
      tx_byte_d = status;                                // RULE1
      if (ser.byte_first) begin
        opc_d     = ser.rx_byte;
        opc_vld_d = 1'b1;
        nb_d      = 2'd1;
        tx_en_d   = (ser.rx_byte == `FSWG_OP_SR_READ);
      end else begin
        if (nb_q == 2'd1) begin
          data1_d = ser.rx_byte;
        end
        if (nb_q != 2'd3) begin
          nb_d = nb_q + 2'd1;
        end
      end
    end
    case (state_q)
      fswg_pkg::FSWG_ST_NV: begin
        if (timer_q == '0) begin
          nv_d     = pend_q;                             // RULE19 RULE8
          permit_d = 1'b0;                               // RULE16
          state_d  = fswg_pkg::FSWG_ST_IDLE;             // RULE12
        end else begin
          timer_d = timer_q - 1'b1;
        end
      end
      fswg_pkg::FSWG_ST_EXT: begin
        if (op_done) begin
          permit_d = 1'b0;                               // RULE16
          state_d  = fswg_pkg::FSWG_ST_IDLE;             // RULE12
        end
      end
      default: begin
      end
    endcase
    if (ser.frame_end) begin
      tx_en_d   = 1'b0;                                  // RULE1
      opc_vld_d = 1'b0;
      arm_d     = 1'b0;
      if (whole) begin
        case (opc_q)
          `FSWG_OP_SET_PERMIT: begin
            if (idle && nb_q == 2'd1) begin
              permit_d = 1'b1;                           // RULE14 RULE11
            end
          end
          `FSWG_OP_CLR_PERMIT: begin
            if (idle && nb_q == 2'd1) begin
              permit_d = 1'b0;                           // RULE16 RULE4
            end
          end
          `FSWG_OP_RESET_EN: begin
            arm_d = (nb_q == 2'd1);
          end
          `FSWG_OP_RESET: begin
            // reset is honoured even while busy; pending work is dropped
            if (arm_q && nb_q == 2'd1) begin
              srst_d   = 1'b1;                           // RULE11
              permit_d = 1'b0;
              state_d  = fswg_pkg::FSWG_ST_IDLE;
            end
          end
          `FSWG_OP_SUSPEND_A, `FSWG_OP_SUSPEND_B: begin
            susp_d = (state_q == fswg_pkg::FSWG_ST_EXT); // RULE11
          end
          `FSWG_OP_SR_WRITE: begin
            // permit bit of the data byte is discarded; latch holds until write end
            if (idle && permit_q && nb_q >= 2'd2 &&
                !sr_locked) begin                        // RULE13 RULE18
              pend_d  = data1_q[7:`FSWG_SR_NV_LSB];      // RULE4
              timer_d = `FSWG_TIMER_W'(SR_CYC - 1);
              state_d = fswg_pkg::FSWG_ST_NV;            // RULE10
            end
          end
          default: begin
            // permit-list codes start the sequencer when idle with latch set, chip erase only at protection level 0; others are ignored
            if (idle && permit_q && need_permit &&
                !(chip_erase &&
                  nv_q[`FSWG_NV_PROT_W-1:0] != '0)) begin // RULE13 RULE17
              start_d   = 1'b1;
              op_code_d = opc_q;
              state_d   = fswg_pkg::FSWG_ST_EXT;         // RULE10
            end
          end
        endcase
      end
    end
    busy_d = (state_d != fswg_pkg::FSWG_ST_IDLE);        // RULE10
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q   <= fswg_pkg::FSWG_ST_IDLE;
      timer_q   <= '0;
      nv_q      <= `FSWG_SR_NV_W'(                       // RULE9
                     `FSWG_STATUS_RST >> `FSWG_SR_NV_LSB);
      pend_q    <= '0;
      permit_q  <= 1'b0;
      busy_q    <= 1'b0;
      opc_q     <= 8'h00;
      opc_vld_q <= 1'b0;
      data1_q   <= 8'h00;
      nb_q      <= 2'd0;
      arm_q     <= 1'b0;
      tx_en_q   <= 1'b0;
      tx_byte_q <= `FSWG_STATUS_RST;
      op_code_q <= 8'h00;
      start_q   <= 1'b0;
      susp_q    <= 1'b0;
      srst_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      timer_q   <= timer_d;
      nv_q      <= nv_d;
      pend_q    <= pend_d;
      permit_q  <= permit_d;
      busy_q    <= busy_d;
      opc_q     <= opc_d;
      opc_vld_q <= opc_vld_d;
      data1_q   <= data1_d;
      nb_q      <= nb_d;
      arm_q     <= arm_d;
      tx_en_q   <= tx_en_d;
      tx_byte_q <= tx_byte_d;
      op_code_q <= op_code_d;
      start_q   <= start_d;
      susp_q    <= susp_d;
      srst_q    <= srst_d;
    end
  end

  assign ser.tx_en           = tx_en_q;
  assign ser.tx_byte         = tx_byte_q;
  assign op_busy_flag        = busy_q;
  assign modify_permit_latch = permit_q;
  assign prot_level          = nv_q[`FSWG_NV_PROT_W-1:0];  // RULE5
  assign four_lane_enable    = nv_q[`FSWG_NV_QUAD_BIT];    // RULE6
  assign status_lock         = nv_q[`FSWG_NV_LOCK_BIT];    // RULE7
  assign op_start            = start_q;
  assign op_code             = op_code_q;
  assign suspend_req         = susp_q;
  assign soft_reset_req      = srst_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  busy_tracks_state_a: assert property ( // RULE2
    busy_q == (state_q != fswg_pkg::FSWG_ST_IDLE))
    else $error("busy flag disagrees with state");
  reset_zero_a: assert property ( // RULE9
    $fell(rst) |-> (status == `FSWG_STATUS_RST))
    else $error("status not zero after reset");
  permit_set_a: assert property ( // RULE14
    ser.frame_end && whole && idle && nb_q == 2'd1 &&
    opc_q == `FSWG_OP_SET_PERMIT |=> permit_q)
    else $error("set-permit did not set latch");
  permit_source_a: assert property ( // RULE4
    $rose(permit_q) |-> $past(opc_q) == `FSWG_OP_SET_PERMIT &&
    $past(ser.frame_end))
    else $error("latch set by other than set-permit");
  gate_permit_a: assert property ( // RULE13
    $rose(op_start) || $rose(state_q == fswg_pkg::FSWG_ST_NV)
    |-> $past(permit_q) && $past(idle))
    else $error("operation started without permit or while busy");
  op_end_clear_a: assert property ( // RULE16
    state_q == fswg_pkg::FSWG_ST_EXT && op_done
    |=> !permit_q && !busy_q)
    else $error("completion did not clear permit and busy");
  locked_ignore_a: assert property ( // RULE18
    ser.frame_end && whole && idle && sr_locked &&
    opc_q == `FSWG_OP_SR_WRITE |=> idle ##1 $stable(nv_q))
    else $error("locked status register was written");
  nv_at_end_a: assert property ( // RULE19
    $changed(nv_q) |-> $past(state_q) == fswg_pkg::FSWG_ST_NV &&
    idle && nv_q == $past(pend_q))
    else $error("non-volatile bits changed outside write end");
  read_repeat_a: assert property ( // RULE1
    tx_en_q && ser.byte_stb |=> tx_byte_q == $past(status))
    else $error("status read did not repeat register value");

  sr_write_c: cover property (
    state_q == fswg_pkg::FSWG_ST_NV ##1 idle);
  ext_op_c: cover property (op_start ##[1:1000] op_done);
  sr_read_c: cover property (tx_en_q && ser.byte_stb && !ser.byte_first);
  locked_c: cover property (
    ser.frame_end && sr_locked && opc_q == `FSWG_OP_SR_WRITE);
endmodule : fswg_status_gate
`default_nettype wire

// [rtl/fswg_cfg.svh]
// fswg_cfg.svh: numeric constants of the flash status write gate.
// assumes: included by bare name from rtl/ sources only.
`ifndef FSWG_CFG_SVH
`define FSWG_CFG_SVH

// ****************************************************************
// status register layout
// ****************************************************************
`define FSWG_STATUS_RST      8'h00
`define FSWG_SR_BUSY_BIT     0
`define FSWG_SR_PERMIT_BIT   1
`define FSWG_SR_NV_LSB       2
`define FSWG_SR_NV_W         6
`define FSWG_NV_LOCK_BIT     5
`define FSWG_NV_QUAD_BIT     4
`define FSWG_NV_PROT_W       4

// ****************************************************************
// instruction codes
// ****************************************************************
`define FSWG_OP_SET_PERMIT   8'h06
`define FSWG_OP_CLR_PERMIT   8'h04
`define FSWG_OP_SR_WRITE     8'h01
`define FSWG_OP_SR_READ      8'h05
`define FSWG_OP_RESET_EN     8'h66
`define FSWG_OP_RESET        8'h99
`define FSWG_OP_SUSPEND_A    8'h75
`define FSWG_OP_SUSPEND_B    8'hB0
`define FSWG_OP_CHIP_ERASE_A 8'hC7
`define FSWG_OP_CHIP_ERASE_B 8'h60
`define FSWG_PERMIT_OP_NUM   30
`define FSWG_PERMIT_OPS '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E, \
  8'hD7, 8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC, 8'hC7, 8'h60, \
  8'h01, 8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h15, 8'h18, 8'hFD, \
  8'hE3, 8'hE4, 8'h2F, 8'hA6, 8'h91, 8'hE8}

// ****************************************************************
// timing
// ****************************************************************
`define FSWG_CLK_MHZ         50
`define FSWG_SR_WRITE_NS     2000
`define FSWG_TIMER_W         16

`endif

// [rtl/fswg_pkg.sv]
// fswg_pkg: types shared by the flash status write gate modules.
// assumes: numbers live in fswg_cfg.svh, not here.
package fswg_pkg;
  typedef logic [7:0] fswg_byte_t;
  typedef enum logic [2:0] {
    FSWG_ST_IDLE = 3'b001,
    FSWG_ST_NV   = 3'b010,
    FSWG_ST_EXT  = 3'b100
  } fswg_state_e;
endpackage : fswg_pkg

// [rtl/fswg_ser_if.sv]
// fswg_ser_if: byte level link between serial shifter and decoder.
// assumes: one sys_clk domain; strobes are one cycle wide.
`timescale 1ns/1ns
`default_nettype none
interface fswg_ser_if;
  logic               byte_stb;
  fswg_pkg::fswg_byte_t rx_byte;
  logic               byte_first;
  logic               frame_end;
  logic               frame_aligned;
  logic               tx_en;
  fswg_pkg::fswg_byte_t tx_byte;
  modport shifter (output byte_stb, rx_byte, byte_first, frame_end,
                   output frame_aligned, input tx_en, tx_byte);
  modport decoder (input byte_stb, rx_byte, byte_first, frame_end,
                   input frame_aligned, output tx_en, tx_byte);
endinterface : fswg_ser_if
`default_nettype wire

// [rtl/fswg_shift.sv]
// fswg_shift: serial bus byte shifter, mode 0 and mode 3.
// assumes: cs_n, sck, si synchronous to sys_clk; each sck phase
// lasts at least four sys_clk cycles.
`timescale 1ns/1ns
`default_nettype none
module fswg_shift (
  input  wire logic    sys_clk,
  input  wire logic    rst,
  input  wire logic    cs_n,
  input  wire logic    sck,
  input  wire logic    si,
  output logic         so_out,
  output logic         so_oe,
  fswg_ser_if.shifter  ser
);
  logic       sck_prev_q, sck_prev_d, cs_prev_q, cs_prev_d;
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] rx_sh_q, rx_sh_d, rx_byte_q, rx_byte_d;
  logic [7:0] tx_sh_q, tx_sh_d;
  logic       first_q, first_d, stb_q, stb_d, bfirst_q, bfirst_d;
  logic       fend_q, fend_d, align_q, align_d;
  logic       so_q, so_d, oe_q, oe_d;
  logic       rise, fall;

  always_comb begin
    rise      = !cs_n && sck && !sck_prev_q;
    fall      = !cs_n && !sck && sck_prev_q;
    sck_prev_d = sck;
    cs_prev_d = cs_n;
    bit_cnt_d = bit_cnt_q;
    rx_sh_d   = rx_sh_q;
    rx_byte_d = rx_byte_q;
    tx_sh_d   = tx_sh_q;
    first_d   = first_q;
    stb_d     = 1'b0;
    bfirst_d  = bfirst_q;
    fend_d    = 1'b0;
    align_d   = align_q;
    so_d      = so_q;
    oe_d      = oe_q && !cs_n && ser.tx_en;
    if (cs_n && !cs_prev_q) begin
      fend_d    = 1'b1;
      align_d   = (bit_cnt_q == 3'd0);
      bit_cnt_d = 3'd0;
      first_d   = 1'b1;
    end else if (rise) begin
      rx_sh_d   = {rx_sh_q[6:0], si};
      bit_cnt_d = bit_cnt_q + 3'd1;
      if (bit_cnt_q == 3'd7) begin
        stb_d     = 1'b1;
        rx_byte_d = {rx_sh_q[6:0], si};
        bfirst_d  = first_q;
        first_d   = 1'b0;
      end
    end
    // output bits change on falling edges, host samples on rising
    if (fall && ser.tx_en) begin
      oe_d = 1'b1;
      if (bit_cnt_q == 3'd0) begin
        so_d    = ser.tx_byte[7];
        tx_sh_d = {ser.tx_byte[6:0], 1'b0};
      end else begin
        so_d    = tx_sh_q[7];
        tx_sh_d = {tx_sh_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
      bit_cnt_q  <= 3'd0;
      rx_sh_q    <= 8'h00;
      rx_byte_q  <= 8'h00;
      tx_sh_q    <= 8'h00;
      first_q    <= 1'b1;
      stb_q      <= 1'b0;
      bfirst_q   <= 1'b0;
      fend_q     <= 1'b0;
      align_q    <= 1'b0;
      so_q       <= 1'b0;
      oe_q       <= 1'b0;
    end else begin
      sck_prev_q <= sck_prev_d;
      cs_prev_q  <= cs_prev_d;
      bit_cnt_q  <= bit_cnt_d;
      rx_sh_q    <= rx_sh_d;
      rx_byte_q  <= rx_byte_d;
      tx_sh_q    <= tx_sh_d;
      first_q    <= first_d;
      stb_q      <= stb_d;
      bfirst_q   <= bfirst_d;
      fend_q     <= fend_d;
      align_q    <= align_d;
      so_q       <= so_d;
      oe_q       <= oe_d;
    end
  end

  assign ser.byte_stb      = stb_q;
  assign ser.rx_byte       = rx_byte_q;
  assign ser.byte_first    = bfirst_q;
  assign ser.frame_end     = fend_q;
  assign ser.frame_aligned = align_q;
  assign so_out            = so_q;
  assign so_oe             = oe_q;
endmodule : fswg_shift
`default_nettype wire

// [tb/fswg_host.sv]
// fswg_host: serial bus host model, mode 0 or 3, one byte lane.
// assumes: caller is just after a sys_clk rising edge when a frame
// starts; each sck phase lasts four sys_clk cycles.
`timescale 1ns/1ns
`default_nettype none
module fswg_host (
  input  wire logic sys_clk,
  input  wire logic so_out,
  input  wire logic so_oe,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  logic so_last;

  initial begin
    cs_n    = 1'b1;
    sck     = 1'b0;
    si      = 1'b0;
    so_last = 1'b0;
  end

  task automatic phase();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  // *****************************************************
  // one frame: n whole bytes out, n bytes captured
  // *****************************************************
  task automatic xfer(input fswg_pkg::fswg_byte_t tx [8], input int n,
                      input logic m3,
                      output fswg_pkg::fswg_byte_t rx [8]);
    logic w;
    // idle level moves only while deselected, so no false edge
    if (sck !== m3) begin
      sck = m3;
      phase();
    end
    cs_n = 1'b0;
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        sck = 1'b0;
        si  = tx[b][i];
        phase();
        // released line has no pull: show the inverse of the last bit
        w       = so_oe ? so_out : ~so_last;
        so_last = w;
        rx[b][i] = w;
        sck = 1'b1;
        phase();
      end
    end
    sck = m3;
    phase();
    cs_n = 1'b1;
    phase();
  endtask
endmodule // fswg_host
`default_nettype wire

// [tb/testbench.sv]
// testbench: self-checking bench of the flash status write gate.
// assumes: fswg_host drives the serial pins; the bench plays the
// array sequencer on op_done and drives the protect pin.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic       sys_clk = 1'b0;
  logic       rst     = 1'b1;
  logic       wp_n    = 1'b1;
  logic       op_done = 1'b0;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       so_out;
  logic       so_oe;
  logic       op_busy_flag;
  logic       modify_permit_latch;
  logic [3:0] prot_level;
  logic       four_lane_enable;
  logic       status_lock;
  logic       op_start;
  logic [7:0] op_code;
  logic       suspend_req;
  logic       soft_reset_req;
  int         err_count = 0;
  int         n_checks  = 0;
  int         cyc       = 0;
  int         n_start   = 0;
  int         n_susp    = 0;
  int         n_srst    = 0;
  int         busy_len  = 0;
  logic       busy_q    = 1'b0;
  logic       m3        = 1'b0;
  logic [7:0] code_seen = 8'h00;
  logic [5:0] nv_at_busy = 6'h00;
  fswg_pkg::fswg_byte_t tx [8];
  fswg_pkg::fswg_byte_t rx [8];

  always #10 sys_clk = ~sys_clk;

  // short status write time: 100 ns is five cycles
  fswg_status_gate #(.SR_WRITE_NS(100)) i_fswg_status_gate (
    .sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
    .wp_n(wp_n), .op_done(op_done), .so_out(so_out), .so_oe(so_oe),
    .op_busy_flag(op_busy_flag),
    .modify_permit_latch(modify_permit_latch),
    .prot_level(prot_level), .four_lane_enable(four_lane_enable),
    .status_lock(status_lock), .op_start(op_start),
    .op_code(op_code), .suspend_req(suspend_req),
    .soft_reset_req(soft_reset_req));

  fswg_host i_host (
    .sys_clk(sys_clk), .so_out(so_out), .so_oe(so_oe),
    .cs_n(cs_n), .sck(sck), .si(si));

  // *****************************************************
  // monitor of pulses, busy length and timeout
  // *****************************************************
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (op_start === 1'b1) begin
      n_start   = n_start + 1;
      code_seen = op_code;
    end
    if (suspend_req === 1'b1) n_susp = n_susp + 1;
    if (soft_reset_req === 1'b1) n_srst = n_srst + 1;
    if (op_busy_flag === 1'b1) begin
      if (busy_q !== 1'b1) begin
        nv_at_busy = {status_lock, four_lane_enable, prot_level};
        busy_len   = 0;
      end
      busy_len = busy_len + 1;
    end
    busy_q = op_busy_flag;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      $display("ERROR timeout expected done seen hang");
      test_done();
    end
  end

  function automatic logic [7:0] sr();
    return {status_lock, four_lane_enable, prot_level,
            modify_permit_latch, op_busy_flag};
  endfunction

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic frm(input fswg_pkg::fswg_byte_t op,
                     input fswg_pkg::fswg_byte_t d, input int n);
    for (int b = 0; b < 8; b++) tx[b] = (b == 0) ? op : d;
    i_host.xfer(tx, n, m3, rx);
  endtask

  task automatic wait_idle();
    for (int k = 0; k < 50 && op_busy_flag !== 1'b0; k++) begin
      @(posedge sys_clk);
      #1;
    end
  endtask

  // *****************************************************
  // scenarios
  // *****************************************************
  task automatic t_reset();
    chk("status after reset", 8'h00, sr());
    frm(8'h05, 8'h00, 2);
    chk("read after reset", 8'h00, rx[1]);
  endtask

  task automatic t_permit();
    frm(8'h06, 8'h00, 1);
    chk("permit set", 8'h02, sr());
    frm(8'h05, 8'h00, 4);
    for (int b = 1; b < 4; b++) chk("read repeat", 8'h02, rx[b]);
    m3 = 1'b1;
    frm(8'h05, 8'h00, 3);
    m3 = 1'b0;
    chk("read mode 3", 8'h02, rx[1]);
    chk("repeat mode 3", 8'h02, rx[2]);
    frm(8'h04, 8'h00, 1);
    chk("permit clear", 8'h00, sr());
  endtask

  task automatic t_sr_write();
    frm(8'h01, 8'hFC, 2);
    chk("write without permit", 8'h00, sr());
    frm(8'h06, 8'h00, 1);
    frm(8'h01, 8'hFE, 2);
    chk("busy during write", 8'h03, sr());
    wait_idle();
    chk("nv applied", 8'hFC, sr());
    chk("nv held while busy", 8'h00, {2'b00, nv_at_busy});
    chk("busy length", 8'h05, 8'(busy_len));
    frm(8'h06, 8'h00, 1);
    frm(8'hC7, 8'h00, 1);
    chk("protected chip erase", 8'h00, 8'(n_start));
    wp_n = 1'b0;
    frm(8'h06, 8'h00, 1);
    frm(8'h01, 8'h00, 2);
    chk("locked write", 8'hFE, sr());
    wp_n = 1'b1;
    frm(8'h06, 8'h00, 1);
    frm(8'h01, 8'h00, 2);
    wait_idle();
    chk("unlocked write", 8'h00, sr());
  endtask

  task automatic t_ext_op();
    frm(8'h06, 8'h00, 1);
    frm(8'h02, 8'h00, 5);
    chk("start count", 8'h01, 8'(n_start));
    chk("op code", 8'h02, code_seen);
    chk("busy ext", 8'h03, sr());
    frm(8'h04, 8'h00, 1);
    chk("clear while busy", 8'h03, sr());
    frm(8'h05, 8'h00, 3);
    chk("read while busy", 8'h03, rx[1]);
    chk("read repeat busy", 8'h03, rx[2]);
    frm(8'h75, 8'h00, 1);
    chk("suspend", 8'h01, 8'(n_susp));
    frm(8'h20, 8'h00, 4);
    chk("erase while busy", 8'h01, 8'(n_start));
    op_done = 1'b1;
    @(posedge sys_clk);
    #1;
    op_done = 1'b0;
    chk("done clears", 8'h00, sr());
    frm(8'h02, 8'h00, 5);
    chk("program without permit", 8'h01, 8'(n_start));
  endtask

  task automatic t_soft_reset();
    frm(8'h06, 8'h00, 1);
    frm(8'hD8, 8'h00, 4);
    chk("second start", 8'h02, 8'(n_start));
    chk("erase code", 8'hD8, code_seen);
    frm(8'h66, 8'h00, 1);
    frm(8'h99, 8'h00, 1);
    chk("soft reset", 8'h01, 8'(n_srst));
    chk("after soft reset", 8'h00, sr());
    frm(8'h06, 8'h00, 1);
    chk("accepts again", 8'h02, sr());
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    @(posedge sys_clk);
    #1;
    t_reset();
    t_permit();
    t_sr_write();
    t_ext_op();
    t_soft_reset();
    test_done();
  end
endmodule // testbench
`default_nettype wire
